//--- logic/power_switch_supervisor.sv
// Top of the power switch supervisor with its register port
// How it works
// - Force-on bit keeps max-supply selection active regardless of other bits.
// - Battery falling through monitor threshold raises an interrupt.
// - That falling event turns off switches chosen in register 8.
// - Recovery comparator rising turns back on the switches turned off.
// - Converter and central over-temperature flags are ORed together.
// - Amplifier supply gating applies equally to all other gated switches.
// - Digital reset disables regulator, converter unless held and not over-temperature, all switches.
// - Microcontroller bias output stays on through and after reset.
// - After reset every register returns to its default value.
// - Power-up clear released at high battery level, asserted at low.
//
// Local design decisions: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module power_switch_supervisor (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Register port
   input wire logic [psup_pkg::ADDR_W-1:0] regAddr,
   input wire logic [psup_pkg::DATA_W-1:0] regWdata,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [psup_pkg::DATA_W-1:0] regRdata,
   // Battery level and comparator flags
   input wire logic batteryRiseOk,
   input wire logic batteryFallLow,
   input wire logic monitorFall,
   input wire logic recoveryHigh,
   // Temperature sensor flags
   input wire logic otConverter,
   input wire logic otCentral,
   // Configuration hold of the converter enable
   input wire logic converterHold,
   // Power controls
   output logic maxSelectForceOn,
   output logic converterEnable,
   output logic regulatorEnable,
   output logic [psup_pkg::NUM_SW-1:0] switchEnable,
   output logic microBiasSupply,
   output logic digitalPowerUpClearN,
   // Interrupt
   output logic irq
);
   localparam int NSW = psup_pkg::NUM_SW;

   logic clearActive;
   logic digReset;
   logic overTemp;
   logic overTempPrev;
   logic monitorPrev;
   logic recoveryPrev;
   logic fallEvt;
   logic recEvt;
   logic otEvt;
   logic [psup_pkg::CTRL_W-1:0] ctrl;
   logic [NSW-1:0] switchReq;
   logic [NSW-1:0] discSel;
   logic [NSW-1:0] heldOff;
   logic [psup_pkg::IRQ_W-1:0] intStatus;
   logic [psup_pkg::IRQ_W-1:0] intMask;
   logic [psup_pkg::IRQ_W-1:0] intClear;
   logic [psup_pkg::IRQ_W-1:0] intSet;
   logic [psup_pkg::DATA_W-1:0] next_rdata;
   psup_pkg::psup_state_type state;

   psup_gate_if gateBus ();

   // Power-up clear hysteresis
   psup_puc_latch uPuc (
      .clk(clk),
      .rstn(rstn),
      .batteryRiseOk(batteryRiseOk),
      .batteryFallLow(batteryFallLow),
      .clearActive(clearActive)
   );

   // Over-temperature gate
   psup_ot_gate uGate (
      .gateBus(gateBus)
   );

   // Digital reset from the pin or the power-up clear
   assign digReset = !rstn || clearActive;

   // Single over-temperature condition
   assign overTemp = otConverter | otCentral;

   // Requests into the gate, collapse hold applied first
   assign gateBus.request = switchReq & ~heldOff;
   assign gateBus.convRequest = ctrl[psup_pkg::CTRL_CONV_EN];
   assign gateBus.overTemp = overTemp;

   // Edge detection of the analog flags
   always_ff @(posedge clk)
   begin
      if (digReset)
      begin
         monitorPrev <= 1'b0;
         recoveryPrev <= 1'b0;
         overTempPrev <= 1'b0;
      end
      else
      begin
         monitorPrev <= monitorFall;
         recoveryPrev <= recoveryHigh;
         overTempPrev <= overTemp;
      end
   end

   assign fallEvt = monitorFall & ~monitorPrev;
   assign recEvt = recoveryHigh & ~recoveryPrev;
   assign otEvt = overTemp & ~overTempPrev;

   // Control registers written by software
   always_ff @(posedge clk)
   begin
      if (digReset)
      begin
         ctrl <= psup_pkg::CTRL_RESET;
         switchReq <= psup_pkg::SWITCH_RESET;
         discSel <= psup_pkg::DISC_SEL_RESET;
         intMask <= psup_pkg::INT_MASK_RESET;
      end
      else if (regWrite)
      begin
         if (regAddr == psup_pkg::ADDR_CTRL)
            ctrl <= regWdata[psup_pkg::CTRL_W-1:0];
         else if (regAddr == psup_pkg::ADDR_SWITCH)
            switchReq <= regWdata[NSW-1:0];
         else if (regAddr == psup_pkg::ADDR_DISC_SEL)
            discSel <= regWdata[NSW-1:0];
         else if (regAddr == psup_pkg::ADDR_INT_MASK)
            intMask <= regWdata[psup_pkg::IRQ_W-1:0];
      end
   end

   // Battery collapse tracking
   always_ff @(posedge clk)
   begin
      if (digReset)
      begin
         state <= psup_pkg::PSUP_NORMAL;
         heldOff <= '0;
      end
      else
      begin
         case (state)
            psup_pkg::PSUP_NORMAL:
               if (fallEvt)
               begin
                  heldOff <= switchReq & discSel;
                  state <= psup_pkg::PSUP_COLLAPSED;
               end
            psup_pkg::PSUP_COLLAPSED:
               if (recEvt)
               begin
                  heldOff <= '0;
                  state <= psup_pkg::PSUP_NORMAL;
               end
            default:
            begin
               heldOff <= '0;
               state <= psup_pkg::PSUP_NORMAL;
            end
         endcase
      end
   end

   // Interrupt status, set wins over write-one clear
   assign intClear = (regWrite && regAddr == psup_pkg::ADDR_INT_STATUS) ?
                     regWdata[psup_pkg::IRQ_W-1:0] : '0;
   assign intSet = {otEvt,
                    recEvt && state == psup_pkg::PSUP_COLLAPSED,
                    fallEvt};

   always_ff @(posedge clk)
   begin
      if (digReset)
         intStatus <= '0;
      else
         intStatus <= (intStatus & ~intClear) | intSet;
   end

   // Interrupt output level
   always_ff @(posedge clk)
   begin
      if (digReset)
         irq <= 1'b0;
      else
         irq <= |(((intStatus & ~intClear) | intSet) & intMask);
   end

   // Power control outputs
   always_ff @(posedge clk)
   begin
      if (digReset)
      begin
         regulatorEnable <= 1'b0;
         switchEnable <= '0;
         converterEnable <= converterHold & ~overTemp;
         maxSelectForceOn <= 1'b0;
      end
      else
      begin
         regulatorEnable <= ctrl[psup_pkg::CTRL_REG_EN];
         switchEnable <= gateBus.gatedSwitch;
         converterEnable <= gateBus.gatedConv;
         maxSelectForceOn <= ctrl[psup_pkg::CTRL_FORCE_ON] |
            (ctrl[psup_pkg::CTRL_AUTO_SEL] & gateBus.gatedConv);
      end
   end

   // Always-on bias and power-up clear pin
   always_ff @(posedge clk)
   begin
      microBiasSupply <= 1'b1;
      digitalPowerUpClearN <= !clearActive;
   end

   // Read data selection
   always_comb
   begin
      next_rdata = '0;
      if (!regRead)
         next_rdata = '0;
      else if (regAddr == psup_pkg::ADDR_CTRL)
         next_rdata[psup_pkg::CTRL_W-1:0] = ctrl;
      else if (regAddr == psup_pkg::ADDR_SWITCH)
         next_rdata[NSW-1:0] = switchReq;
      else if (regAddr == psup_pkg::ADDR_STATUS)
      begin
         next_rdata[psup_pkg::ST_OVER_TEMP] = overTemp;
         next_rdata[psup_pkg::ST_COLLAPSED] =
            (state == psup_pkg::PSUP_COLLAPSED);
         next_rdata[psup_pkg::ST_MON_FALL] = monitorFall;
         next_rdata[psup_pkg::ST_RECOVERY] = recoveryHigh;
      end
      else if (regAddr == psup_pkg::ADDR_INT_STATUS)
         next_rdata[psup_pkg::IRQ_W-1:0] = intStatus;
      else if (regAddr == psup_pkg::ADDR_INT_MASK)
         next_rdata[psup_pkg::IRQ_W-1:0] = intMask;
      else if (regAddr == psup_pkg::ADDR_HELD)
         next_rdata[NSW-1:0] = heldOff;
      else if (regAddr == psup_pkg::ADDR_DISC_SEL)
         next_rdata[NSW-1:0] = discSel;
   end

   // Read data register, valid one cycle after the strobe
   always_ff @(posedge clk)
   begin
      if (!rstn)
         regRdata <= '0;
      else
         regRdata <= next_rdata;
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (digReset);

   force_on_a: assert property
      (ctrl[psup_pkg::CTRL_FORCE_ON] |=> maxSelectForceOn)
      else $error("force-on bit did not keep max selection on");
   fall_irq_a: assert property
      (fallEvt && intMask[psup_pkg::IRQ_FALL] |=> irq [*2])
      else $error("falling battery did not raise interrupt");
   fall_disc_a: assert property
      (fallEvt && state == psup_pkg::PSUP_NORMAL
       |=> heldOff == ($past(switchReq) & $past(discSel)))
      else $error("wrong switches held off on collapse");
   held_off_a: assert property
      (!$past(digReset) |-> (switchEnable & $past(heldOff)) == '0)
      else $error("held-off switch still enabled");
   recover_on_a: assert property
      (state == psup_pkg::PSUP_COLLAPSED && recEvt
       |=> heldOff == '0 && state == psup_pkg::PSUP_NORMAL)
      else $error("recovery did not restore switches");
   ot_or_a: assert property
      ($rose(otConverter || otCentral) |=>
       intStatus[psup_pkg::IRQ_OVER_TEMP])
      else $error("either temperature flag must set over-temp");
   ot_force_a: assert property
      (overTemp |=> switchEnable == '0 && !converterEnable)
      else $error("over-temperature did not force enables off");
   ot_release_a: assert property
      (!overTemp && !$past(digReset) && heldOff == '0
       |=> switchEnable == $past(switchReq))
      else $error("switches not released after over-temperature");
   reset_off_a: assert property (disable iff (1'b0)
      digReset |=> !regulatorEnable && switchEnable == '0)
      else $error("reset left regulator or switches on");
   bias_on_a: assert property (disable iff (1'b0)
      1'b1 |=> microBiasSupply)
      else $error("micro bias supply dropped");
   defaults_a: assert property (disable iff (1'b0)
      digReset |=> ctrl == psup_pkg::CTRL_RESET &&
      discSel == psup_pkg::DISC_SEL_RESET && intStatus == '0)
      else $error("register not at default after reset");

   collapse_cycle_c: cover property
      (state == psup_pkg::PSUP_COLLAPSED ##[1:20]
       state == psup_pkg::PSUP_NORMAL);
   over_temp_c: cover property (otEvt ##1 switchEnable == '0);
   irq_seen_c: cover property (irq ##1 !irq);
endmodule : power_switch_supervisor

//--- logic/psup_pkg.sv
// Shared constants and types of the power switch supervisor
package psup_pkg;
   // Data and address widths of the register port
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int NUM_SW = 7;

   // Register addresses
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_SWITCH = 8'h01;
   localparam logic [7:0] ADDR_STATUS = 8'h02;
   localparam logic [7:0] ADDR_INT_STATUS = 8'h03;
   localparam logic [7:0] ADDR_INT_MASK = 8'h04;
   localparam logic [7:0] ADDR_HELD = 8'h05;
   localparam logic [7:0] ADDR_DISC_SEL = 8'h08;

   // Control register fields
   localparam int CTRL_FORCE_ON = 0;
   localparam int CTRL_REG_EN = 1;
   localparam int CTRL_CONV_EN = 2;
   localparam int CTRL_AUTO_SEL = 3;
   localparam int CTRL_W = 4;

   // Status register fields
   localparam int ST_OVER_TEMP = 0;
   localparam int ST_COLLAPSED = 1;
   localparam int ST_MON_FALL = 2;
   localparam int ST_RECOVERY = 3;

   // Interrupt fields
   localparam int IRQ_FALL = 0;
   localparam int IRQ_RECOVER = 1;
   localparam int IRQ_OVER_TEMP = 2;
   localparam int IRQ_W = 3;

   // Switch positions
   localparam int SW_PA = 0;
   localparam int SW_SINGLE_WIRE = 1;
   localparam int SW_SERIAL = 2;
   localparam int SW_AUX_A = 3;
   localparam int SW_AUX_B = 4;
   localparam int SW_RADIO = 5;
   localparam int SW_CONV_TO_REG = 6;

   // Reset values
   localparam logic [3:0] CTRL_RESET = 4'h0;
   localparam logic [6:0] SWITCH_RESET = 7'h00;
   localparam logic [6:0] DISC_SEL_RESET = 7'h7F;
   localparam logic [2:0] INT_MASK_RESET = 3'h0;

   // Battery collapse tracking states
   typedef enum logic [1:0] {
      PSUP_NORMAL = 2'b01,
      PSUP_COLLAPSED = 2'b10
   } psup_state_type;
endpackage : psup_pkg

//--- logic/psup_gate_if.sv
// Carrier between the supervisor and its over-temperature gate
`timescale 1ns/1ps
interface psup_gate_if;
   logic [psup_pkg::NUM_SW-1:0] request;
   logic convRequest;
   logic overTemp;
   logic [psup_pkg::NUM_SW-1:0] gatedSwitch;
   logic gatedConv;

   modport source (output request, output convRequest, output overTemp,
                   input gatedSwitch, input gatedConv);
   modport gate (input request, input convRequest, input overTemp,
                 output gatedSwitch, output gatedConv);
endinterface : psup_gate_if

//--- logic/psup_ot_gate.sv
// Over-temperature gating of the converter and load switch enables
`timescale 1ns/1ps
module psup_ot_gate (
   // Requests in, gated enables out
   psup_gate_if.gate gateBus
);
   genvar i;

   // Every switch takes the same gate as the amplifier supply
   generate
      for (i = 0; i < psup_pkg::NUM_SW; i++)
      begin : gSw
         assign gateBus.gatedSwitch[i] =
            gateBus.request[i] & ~gateBus.overTemp;
      end
   endgenerate

   // Converter enable forced off while hot
   assign gateBus.gatedConv = gateBus.convRequest & ~gateBus.overTemp;
endmodule : psup_ot_gate

//--- logic/psup_puc_latch.sv
// Hysteresis latch of the digital power-up clear
`timescale 1ns/1ps
module psup_puc_latch (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Battery level flags
   input wire logic batteryRiseOk,
   input wire logic batteryFallLow,
   // Clear state, high while the logic is held cleared
   output logic clearActive
);
   // Assert at the low level, release at the high level
   always_ff @(posedge clk)
   begin
      if (!rstn)
         clearActive <= 1'b1;
      else if (batteryFallLow)
         clearActive <= 1'b1;
      else if (batteryRiseOk)
         clearActive <= 1'b0;
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   puc_assert_a: assert property (batteryFallLow |=> clearActive)
      else $error("power-up clear not asserted at low battery");
   puc_release_a: assert property
      (batteryRiseOk && !batteryFallLow |=> !clearActive)
      else $error("power-up clear not released at high battery");
   puc_hold_a: assert property
      (!batteryRiseOk && !batteryFallLow |=> $stable(clearActive))
      else $error("power-up clear moved inside hysteresis band");
   puc_cycle_c: cover property (clearActive ##1 !clearActive);
endmodule : psup_puc_latch

//--- bench/test_power_switch_supervisor.sv
// Self-checking bench of the power switch supervisor
`timescale 1ns/1ps
module test_power_switch_supervisor;
   // Clock, reset and register port
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic [7:0] regAddr = 8'h00;
   logic [7:0] regWdata = 8'h00;
   logic regWrite = 1'b0;
   logic regRead = 1'b0;
   logic [7:0] regRdata;
   // Battery, comparator and temperature flags
   logic batteryRiseOk = 1'b1;
   logic batteryFallLow = 1'b0;
   logic monitorFall = 1'b0;
   logic recoveryHigh = 1'b0;
   logic otConverter = 1'b0;
   logic otCentral = 1'b0;
   logic converterHold = 1'b0;
   // Power controls
   logic maxSelectForceOn, converterEnable, regulatorEnable;
   logic [psup_pkg::NUM_SW-1:0] switchEnable;
   logic microBiasSupply, digitalPowerUpClearN, irq;
   // Bench state
   int mismatches = 0;
   int compares = 0;
   int seed = 59138;
   logic [7:0] expQ[$];
   logic rdSeen = 1'b0;
   logic [6:0] sw, disc;
   logic mask;

   power_switch_supervisor u_power_switch_supervisor (
      .clk(clk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata),
      .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
      .batteryRiseOk(batteryRiseOk), .batteryFallLow(batteryFallLow),
      .monitorFall(monitorFall), .recoveryHigh(recoveryHigh),
      .otConverter(otConverter), .otCentral(otCentral),
      .converterHold(converterHold), .maxSelectForceOn(maxSelectForceOn),
      .converterEnable(converterEnable), .regulatorEnable(regulatorEnable),
      .switchEnable(switchEnable), .microBiasSupply(microBiasSupply),
      .digitalPowerUpClearN(digitalPowerUpClearN), .irq(irq)
   );

   // Clock of 50 ns period
   always #25 clk = ~clk;

   // Compare one value and count it
   task automatic check(input string what, input logic [7:0] exp,
      input logic [7:0] got);
      compares++;
      if (got !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   // One-bit compare
   task automatic check1(input string what, input logic exp,
      input logic got);
      check(what, {7'h00, exp}, {7'h00, got});
   endtask : check1

   // Register write, one strobe cycle
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      regAddr <= a;
      regWdata <= d;
      regWrite <= 1'b1;
      @(posedge clk);
      regWrite <= 1'b0;
   endtask : wr

   // Register read, expected data noted for the monitor
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      regAddr <= a;
      regRead <= 1'b1;
      expQ.push_back(e);
      @(posedge clk);
      regRead <= 1'b0;
   endtask : rd

   // Let edges pass, then sample at the falling edge
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask : settle

   // Verdict and end of run
   task automatic summarize();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : summarize

   // Read data monitor, one cycle after each read strobe
   always @(posedge clk) rdSeen <= regRead;
   always @(negedge clk)
   begin
      if (rdSeen)
      begin
         if (expQ.size() == 0)
            check("read data unexpected", 8'h00, 8'hFF);
         else
            check("read data", expQ.pop_front(), regRdata);
      end
   end

   // Watchdog against a hang
   initial
   begin
      repeat (4000) @(posedge clk);
      mismatches++;
      summarize();
   end

   // Main sequence
   initial
   begin
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      settle(2);
      check1("bias", 1'b1, microBiasSupply);
      check1("clear pin", 1'b1, digitalPowerUpClearN);
      check("switches", 8'h00, {1'b0, switchEnable});
      rd(psup_pkg::ADDR_DISC_SEL, 8'h7F);
      rd(psup_pkg::ADDR_CTRL, 8'h00);
      rd(psup_pkg::ADDR_INT_MASK, 8'h00);
      rd(8'h06, 8'h00);
      $display("test defaults done");
      // Force-on alone, then cleared, then set with other bits
      wr(psup_pkg::ADDR_CTRL, 8'h01);
      settle(1);
      check1("force on", 1'b1, maxSelectForceOn);
      // Automatic selection follows the gated converter enable
      wr(psup_pkg::ADDR_CTRL, 8'h0C);
      settle(1);
      check1("auto select on", 1'b1, maxSelectForceOn);
      wr(psup_pkg::ADDR_CTRL, 8'h08);
      settle(1);
      check1("auto select off", 1'b0, maxSelectForceOn);
      wr(psup_pkg::ADDR_CTRL, 8'h06);
      settle(1);
      check1("force off", 1'b0, maxSelectForceOn);
      wr(psup_pkg::ADDR_CTRL, 8'h07);
      settle(1);
      check1("force on", 1'b1, maxSelectForceOn);
      check1("regulator", 1'b1, regulatorEnable);
      check1("converter", 1'b1, converterEnable);
      $display("test force on done");
      // Collapse and recovery with random selections
      for (int k = 0; k < 3; k++)
      begin
         sw = 7'($random(seed)) | 7'h01;
         disc = 7'($random(seed));
         mask = (k != 1);
         wr(psup_pkg::ADDR_SWITCH, {1'b0, sw});
         wr(psup_pkg::ADDR_DISC_SEL, {1'b0, disc});
         wr(psup_pkg::ADDR_INT_MASK, {7'h00, mask});
         settle(1);
         check("switches", {1'b0, sw}, {1'b0, switchEnable});
         @(posedge clk);
         monitorFall <= 1'b1;
         settle(3);
         check("collapsed", {1'b0, sw & ~disc}, {1'b0, switchEnable});
         check1("fall irq", mask, irq);
         rd(psup_pkg::ADDR_HELD, {1'b0, sw & disc});
         rd(psup_pkg::ADDR_INT_STATUS, 8'h01);
         rd(psup_pkg::ADDR_STATUS, 8'h06);
         @(posedge clk);
         monitorFall <= 1'b0;
         recoveryHigh <= 1'b1;
         settle(3);
         check("recovered", {1'b0, sw}, {1'b0, switchEnable});
         rd(psup_pkg::ADDR_HELD, 8'h00);
         rd(psup_pkg::ADDR_INT_STATUS, 8'h03);
         wr(psup_pkg::ADDR_INT_STATUS, 8'h01);
         settle(1);
         check1("irq cleared", 1'b0, irq);
         rd(psup_pkg::ADDR_INT_STATUS, 8'h02);
         wr(psup_pkg::ADDR_INT_STATUS, 8'h07);
         @(posedge clk);
         recoveryHigh <= 1'b0;
         $display("test collapse pass %0d done", k);
      end
      // Each over-temperature source and both together
      wr(psup_pkg::ADDR_INT_MASK, 8'h04);
      for (int k = 1; k < 4; k++)
      begin
         @(posedge clk);
         {otConverter, otCentral} <= 2'(k);
         settle(2);
         check("hot switches", 8'h00, {1'b0, switchEnable});
         check1("hot converter", 1'b0, converterEnable);
         check1("hot force on", 1'b1, maxSelectForceOn);
         check1("hot irq", 1'b1, irq);
         rd(psup_pkg::ADDR_STATUS, 8'h01);
         rd(psup_pkg::ADDR_INT_STATUS, 8'h04);
         wr(psup_pkg::ADDR_INT_STATUS, 8'h04);
         @(posedge clk);
         {otConverter, otCentral} <= 2'b00;
         settle(2);
         check("cool switches", {1'b0, sw}, {1'b0, switchEnable});
         check1("cool converter", 1'b1, converterEnable);
      end
      $display("test over temperature done");
      // Battery falls to the clear level, then rises again
      @(posedge clk);
      converterHold <= 1'($random(seed));
      batteryFallLow <= 1'b1;
      batteryRiseOk <= 1'b0;
      settle(3);
      check("reset switches", 8'h00, {1'b0, switchEnable});
      check1("reset regulator", 1'b0, regulatorEnable);
      check1("reset converter", converterHold, converterEnable);
      check1("reset bias", 1'b1, microBiasSupply);
      check1("clear pin", 1'b0, digitalPowerUpClearN);
      @(posedge clk);
      batteryFallLow <= 1'b0;
      settle(2);
      check1("clear held", 1'b0, digitalPowerUpClearN);
      @(posedge clk);
      batteryRiseOk <= 1'b1;
      settle(3);
      check1("clear released", 1'b1, digitalPowerUpClearN);
      check("restart switches", 8'h00, {1'b0, switchEnable});
      rd(psup_pkg::ADDR_CTRL, 8'h00);
      rd(psup_pkg::ADDR_SWITCH, 8'h00);
      rd(psup_pkg::ADDR_DISC_SEL, 8'h7F);
      settle(2);
      $display("test power-up clear done");
      summarize();
   end
endmodule : test_power_switch_supervisor
